// ---- sctg_clock_timing.v ----
/*
 system clock and timing generator: prescaler, 21-stage divider, main clock
 source switching, four-state machine cycle, oscillator stand-by control and
 an APB register slave. assumes oscillator ticks arrive as one-cycle pulses
 synchronous to sys_clk_in, and a single APB master.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "sctg_regs.vh"

module sctg_clock_timing (
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire dual_osc_option_in,
  input wire fast_osc_in_pin_in,
  input wire slow_osc_in_pin_in,
  input wire stop_release_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output reg [31:0] prdata_out,
  output wire pslverr_out,
  output reg fast_osc_out_pin_out,
  output reg slow_osc_out_pin_out,
  output reg slow_pins_as_port_out,
  output reg main_clk_en_out,
  output reg [1:0] cycle_state_out,
  output reg cycle_start_out,
  output reg instr_done_out,
  output reg divider_pulse_output_out,
  output reg [`SCTG_DIV_STAGES-1:0] div_taps_out,
  output reg warmup_done_out,
  output reg reset_req_b_out
);

  // state of the stand-by controller
  localparam ST_RUN = 2'b00;
  localparam ST_STOPPED = 2'b01;
  localparam ST_WARMUP = 2'b10;

  reg [`SCTG_PRESCALE_W-1:0] prescale_reg;
  reg [`SCTG_DIV_STAGES-1:0] div_reg;
  reg [`SCTG_DIV_STAGES-1:0] div_next;
  reg [7:0] time_base_control_reg;
  reg fast_osc_enable_reg;
  reg slow_osc_enable_reg;
  reg main_clock_source_select_reg;
  reg main_src_active_reg;
  reg dual_mode_reg;
  reg strap_taken_reg;
  reg [1:0] sb_state_reg;
  reg [15:0] slow_cnt_reg;
  reg slow_tick_reg;
  reg fast_tick_d_reg;
  reg [3:0] instr_len_reg;
  reg [3:0] mcycle_cnt_reg;
  reg fast_fail_reg;

  wire apb_wr;
  wire apb_rd;
  wire fast_tick;
  wire main_tick;
  wire stage7_in;
  wire low_run;
  wire [`SCTG_DIV_STAGES-1:0] div_carry;
  wire osc_both_off;
  wire div_clear;

  // one-cycle-ready APB slave: every access completes in the access phase
  assign pready_out = 1'b1;
  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign apb_rd = psel_in & ~penable_in & ~pwrite_in;
  assign pslverr_out = psel_in & penable_in & ~addr_known(paddr_in);

  // decode used by the error path only
  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `SCTG_TIME_BASE_CTRL_OFF) | (a == `SCTG_SYS_CTRL_OFF) |
        (a == `SCTG_STATUS_OFF) | (a == `SCTG_CYCLE_CTRL_OFF);
    end
  endfunction

  // fast oscillator tick: rising edge of the pin while it is enabled
  assign fast_tick = fast_osc_in_pin_in & ~fast_tick_d_reg & fast_osc_enable_reg;
  assign low_run = dual_mode_reg & main_src_active_reg;

  // main clock enable source: the oscillator currently in use
  assign main_tick = (sb_state_reg == ST_RUN) & (low_run ? slow_tick_reg : fast_tick);

  // the stage-seven input, carry out of stage six is fc/256 with the prescaler
  assign stage7_in = (!dual_mode_reg) ? div_carry[`SCTG_STAGE7_IDX-1] :
    (low_run ? slow_tick_reg :
    (time_base_control_reg[`SCTG_STAGE7_SEL_BIT] ? slow_tick_reg :
    div_carry[`SCTG_STAGE7_IDX-1]));

  // ripple carries of the divider; stage one is fed by prescaler wrap
  genvar gi;
  generate
    for (gi = 0; gi < `SCTG_DIV_STAGES; gi = gi + 1) begin : g_carry
      if (gi == 0) begin : g_first
        assign div_carry[gi] = fast_tick & (&prescale_reg) & ~low_run & div_reg[gi];
      end else if (gi == `SCTG_STAGE7_IDX) begin : g_seven
        assign div_carry[gi] = stage7_in & div_reg[gi];
      end else begin : g_rest
        assign div_carry[gi] = div_carry[gi-1] & div_reg[gi];
      end
    end
  endgenerate

  integer int_i;

  // toggle stage i when its input carry arrives
  always @* begin
    div_next = div_reg;
    div_next[0] = div_reg[0] ^ (fast_tick & (&prescale_reg) & ~low_run);
    for (int_i = 1; int_i < `SCTG_DIV_STAGES; int_i = int_i + 1) begin
      if (int_i == `SCTG_STAGE7_IDX) begin
        div_next[int_i] = div_reg[int_i] ^ stage7_in;
      end else begin
        div_next[int_i] = div_reg[int_i] ^ div_carry[int_i-1];
      end
    end
  end

  assign osc_both_off = ~fast_osc_enable_reg & ~slow_osc_enable_reg;
  assign div_clear = (sb_state_reg == ST_STOPPED) & stop_release_in;

  // option strap caught once after reset release, then held
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_taken_reg <= 1'b0;
      dual_mode_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      dual_mode_reg <= dual_osc_option_in;
    end
  end

  // low-frequency oscillator emulated by a divider of the system clock
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slow_cnt_reg <= 16'h0000;
      slow_tick_reg <= 1'b0;
      fast_tick_d_reg <= 1'b0;
    end else begin
      fast_tick_d_reg <= fast_osc_in_pin_in;
      slow_tick_reg <= 1'b0;
      if (dual_mode_reg & slow_osc_enable_reg & slow_osc_in_pin_in) begin
        if (slow_cnt_reg == `SCTG_SLOW_DIV - 16'h0001) begin
          slow_cnt_reg <= 16'h0000;
          slow_tick_reg <= 1'b1;
        end else begin
          slow_cnt_reg <= slow_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // prescaler cleared only by reset; divider cleared on reset and throughout the stopped state
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale_reg <= 2'b00;
      div_reg <= {`SCTG_DIV_STAGES{1'b0}};
    end else begin
      if (fast_tick) begin
        prescale_reg <= prescale_reg + 2'b01;
      end
      if (div_clear | (sb_state_reg == ST_STOPPED)) begin
        div_reg <= {`SCTG_DIV_STAGES{1'b0}};
      end else begin
        div_reg <= div_next;
      end
    end
  end

  // machine cycle: four states, source switch only at the last state
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cycle_state_out <= 2'b00;
      main_clk_en_out <= 1'b0;
      cycle_start_out <= 1'b0;
      instr_done_out <= 1'b0;
      mcycle_cnt_reg <= 4'h1;
      main_src_active_reg <= 1'b0;
    end else begin
      main_clk_en_out <= main_tick;
      cycle_start_out <= 1'b0;
      instr_done_out <= 1'b0;
      if (main_tick) begin
        cycle_state_out <= cycle_state_out + 2'b01;
        if (cycle_state_out == 2'b11) begin
          cycle_start_out <= 1'b1;
          main_src_active_reg <= main_clock_source_select_reg & dual_mode_reg;
          if (mcycle_cnt_reg >= instr_len_reg) begin
            mcycle_cnt_reg <= 4'h1;
            instr_done_out <= 1'b1;
          end else begin
            mcycle_cnt_reg <= mcycle_cnt_reg + 4'h1;
          end
        end
      end
    end
  end

  // stand-by controller: stop, wait for release, warm up, then run
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sb_state_reg <= ST_RUN;
      warmup_done_out <= 1'b0;
    end else begin
      warmup_done_out <= 1'b0;
      case (sb_state_reg)
        ST_RUN: begin
          if (apb_wr & (paddr_in == `SCTG_SYS_CTRL_OFF) & pwdata_in[`SCTG_STOP_BIT]) begin
            sb_state_reg <= ST_STOPPED;
          end
        end
        ST_STOPPED: begin
          if (stop_release_in) begin
            sb_state_reg <= ST_WARMUP;
          end
        end
        ST_WARMUP: begin
          if (div_reg[`SCTG_WARMUP_BIT]) begin
            sb_state_reg <= ST_RUN;
            warmup_done_out <= 1'b1;
          end
        end
        default: sb_state_reg <= ST_RUN;
      endcase
    end
  end

  // software registers
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      time_base_control_reg <= `SCTG_TIME_BASE_RESET;
      fast_osc_enable_reg <= 1'b1;
      slow_osc_enable_reg <= 1'b0;
      main_clock_source_select_reg <= 1'b0;
      instr_len_reg <= 4'h1;
    end else if (apb_wr) begin
      case (paddr_in)
        `SCTG_TIME_BASE_CTRL_OFF: time_base_control_reg <= pwdata_in[7:0];
        `SCTG_SYS_CTRL_OFF: begin
          fast_osc_enable_reg <= pwdata_in[`SCTG_FAST_OSC_EN_BIT];
          slow_osc_enable_reg <= pwdata_in[`SCTG_SLOW_OSC_EN_BIT] & dual_mode_reg;
          main_clock_source_select_reg <= pwdata_in[`SCTG_MAIN_SEL_BIT];
        end
        `SCTG_CYCLE_CTRL_OFF: begin
          // lengths outside one to ten are clamped
          if (pwdata_in[3:0] == 4'h0) begin
            instr_len_reg <= 4'h1;
          end else if (pwdata_in[3:0] > `SCTG_MAX_CYCLES) begin
            instr_len_reg <= `SCTG_MAX_CYCLES;
          end else begin
            instr_len_reg <= pwdata_in[3:0];
          end
        end
        default: instr_len_reg <= instr_len_reg;
      endcase
    end
  end

  // read data latched in the setup phase so it is stable in the access phase
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h00000000;
    end else if (apb_rd) begin
      case (paddr_in)
        `SCTG_TIME_BASE_CTRL_OFF: prdata_out <= {24'h000000, time_base_control_reg};
        `SCTG_SYS_CTRL_OFF: prdata_out <= {24'h000000, fast_osc_enable_reg,
          slow_osc_enable_reg, main_src_active_reg, 5'h00};
        `SCTG_STATUS_OFF: prdata_out <= {27'h0000000, dual_mode_reg,
          sb_state_reg, cycle_state_out};
        `SCTG_CYCLE_CTRL_OFF: prdata_out <= {28'h0000000, instr_len_reg};
        default: prdata_out <= 32'h00000000;
      endcase
    end
  end

  // oscillator drive, divider pulse, taps and the both-off reset
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fast_osc_out_pin_out <= 1'b1;
      slow_osc_out_pin_out <= 1'b1;
      slow_pins_as_port_out <= 1'b1;
      divider_pulse_output_out <= 1'b0;
      div_taps_out <= {`SCTG_DIV_STAGES{1'b0}};
      reset_req_b_out <= 1'b1;
      fast_fail_reg <= 1'b0;
    end else begin
      // inverter drive stops while the oscillator is off or stopped
      fast_osc_out_pin_out <= ~fast_osc_in_pin_in & fast_osc_enable_reg &
        (sb_state_reg != ST_STOPPED);
      slow_osc_out_pin_out <= ~slow_osc_in_pin_in & slow_osc_enable_reg &
        (sb_state_reg != ST_STOPPED);
      slow_pins_as_port_out <= ~dual_mode_reg;
      divider_pulse_output_out <= time_base_control_reg[`SCTG_DIV_OUT_EN_BIT] &
        div_reg[`SCTG_STAGE7_IDX];
      div_taps_out <= div_reg;
      fast_fail_reg <= osc_both_off;
      reset_req_b_out <= ~(osc_both_off | fast_fail_reg);
    end
  end

endmodule

// ---- sctg_regs.vh ----
/*
 register offsets, field positions, reset values and timing counts of the
 system clock and timing generator; assumes byte addressing on a 32-bit APB.
*/
`ifndef SCTG_REGS_VH
`define SCTG_REGS_VH

// register byte offsets
`define SCTG_TIME_BASE_CTRL_OFF 12'h000
`define SCTG_SYS_CTRL_OFF 12'h004
`define SCTG_STATUS_OFF 12'h008
`define SCTG_CYCLE_CTRL_OFF 12'h00c

// time base control fields
`define SCTG_STAGE7_SEL_BIT 4
`define SCTG_DIV_OUT_EN_BIT 7
`define SCTG_TIME_BASE_RESET 8'h00

// system control fields
`define SCTG_STOP_BIT 0
`define SCTG_MAIN_SEL_BIT 5
`define SCTG_SLOW_OSC_EN_BIT 6
`define SCTG_FAST_OSC_EN_BIT 7
`define SCTG_SYS_CTRL_RESET 8'h80

// divider shape
`define SCTG_PRESCALE_W 2
`define SCTG_DIV_STAGES 21
`define SCTG_STAGE7_IDX 6
`define SCTG_MAX_CYCLES 4'ha

// low-frequency tick rate: one slow tick per this many system clocks
`define SCTG_SLOW_DIV 16'h0262

// divider stage whose setting ends the warm-up after stop release
`define SCTG_WARMUP_BIT 14

`endif

// ---- sctg_chk.sv ----
/*
 assertion checker for the clock and timing block.
 assumes it is bound to sctg_clock_timing and sees only its ports.
*/
`timescale 1ns/10ps
module sctg_chk (
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire psel_in,
  input wire penable_in,
  input wire [11:0] paddr_in,
  input wire pslverr_out,
  input wire main_clk_en_out,
  input wire [1:0] cycle_state_out,
  input wire cycle_start_out,
  input wire instr_done_out,
  input wire slow_pins_as_port_out,
  input wire [20:0] div_taps_out
);
  logic [1:0] up_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // edges since reset release; the strap is caught at the first one
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  property p_step;
    main_clk_en_out |-> cycle_state_out == $past(cycle_state_out) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("state did not advance");
  property p_hold;
    !main_clk_en_out |-> $stable(cycle_state_out);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without clock");
  property p_pulse;
    main_clk_en_out |=> !main_clk_en_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clock enable too long");
  property p_start;
    cycle_start_out == (main_clk_en_out && cycle_state_out == 2'h0);
  endproperty
  a_start: assert property (p_start) else $error("cycle start misplaced");
  property p_done;
    instr_done_out |-> cycle_start_out;
  endproperty
  a_done: assert property (p_done) else $error("done off boundary");
  // the low six stages count one step at a time unless cleared
  property p_taps;
    $changed(div_taps_out[5:0]) && div_taps_out != 21'h0
      |-> div_taps_out[5:0] == $past(div_taps_out[5:0]) + 6'h1;
  endproperty
  a_taps: assert property (p_taps) else $error("divider skipped");
  property p_err;
    psel_in && penable_in && paddr_in > 12'h00c |-> pslverr_out;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_strap;
    up_reg == 2'h3 |-> $stable(slow_pins_as_port_out);
  endproperty
  a_strap: assert property (p_strap) else $error("option changed in run");
  c_start: cover property (cycle_start_out);
  c_done: cover property (instr_done_out);
  c_err: cover property (pslverr_out);
endmodule
bind sctg_clock_timing sctg_chk sctg_chk_i (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
  .paddr_in, .pslverr_out, .main_clk_en_out, .cycle_state_out, .cycle_start_out,
  .instr_done_out, .slow_pins_as_port_out, .div_taps_out);

// ---- tb.sv ----
/*
 self-checking bench for sctg_clock_timing.
 assumes a 20 MHz clock and that the bench alone drives apb and pins.
*/
`timescale 1ns/10ps
`include "sctg_regs.vh"
module tb;
  logic clk = 1'b0, rst_b = 1'b0, dual = 1'b0, fpin = 1'b0, spin = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rerr, srel = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h130254bf;
  logic pready, perr, men, cstart, idone, spp, rreq, fout;
  logic [1:0] cst;
  logic [20:0] taps, t0;
  int num_errors = 0, total_checks = 0, gap = 0, cnt = 0, nen = 0;
  int cyc = 0, last = 0, per = 0, i, k;
  sctg_clock_timing sctg_clock_timing_i (.sys_clk_in(clk), .rst_b_in(rst_b),
    .dual_osc_option_in(dual), .fast_osc_in_pin_in(fpin), .slow_osc_in_pin_in(spin),
    .stop_release_in(srel), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(perr), .fast_osc_out_pin_out(fout), .slow_osc_out_pin_out(),
    .slow_pins_as_port_out(spp), .main_clk_en_out(men), .cycle_state_out(cst),
    .cycle_start_out(cstart), .instr_done_out(idone), .divider_pulse_output_out(),
    .div_taps_out(taps), .warmup_done_out(), .reset_req_b_out(rreq));
  always #25 clk = ~clk;
  // reference counts: cycles per instruction, clock pulses, pulse spacing
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cstart === 1'b1) cnt = cnt + 1;
    if (idone === 1'b1) begin
      gap = cnt;
      cnt = 0;
    end
    if (men === 1'b1) begin
      nen = nen + 1;
      per = cyc - last;
      last = cyc;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; waits fewer than 20 clocks for pready, else fails the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      print_verdict();
    end
    rd = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // fast oscillator edges, at least two clocks apart, random spacing
  task automatic ticks(input int n);
    repeat (n) begin
      seed = xs(seed);
      fpin <= 1'b1;
      @(posedge clk);
      fpin <= 1'b0;
      repeat (1 + seed[1:0]) @(posedge clk);
    end
  endtask
  task automatic do_reset(input logic d);
    rst_b <= 1'b0;
    dual <= d;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // the strap lands at the first edge, the port flag one edge later
    repeat (3) @(posedge clk);
  endtask
  initial begin
    do_reset(1'b0);
    cmp("taps", 0, taps);
    cmp("port", 1, spp);
    apb(1'b0, `SCTG_SYS_CTRL_OFF, 0);
    cmp("sysctl", 32'h80, rd);
    apb(1'b0, 12'h010, 0);
    cmp("err", 1, rerr);
    // single mode: one state per fast edge, the divider moves every four
    t0 = taps;
    nen = 0;
    ticks(1024);
    repeat (4) @(posedge clk);
    cmp("states", 1024, nen);
    cmp("taps", t0 + 21'h100, taps);
    // every length plus one above the top, which clamps
    for (k = 1; k <= 11; k++) begin
      apb(1'b1, `SCTG_CYCLE_CTRL_OFF, k);
      apb(1'b0, `SCTG_CYCLE_CTRL_OFF, 0);
      cmp("len", k > 10 ? 10 : k, rd);
      ticks(56 + 8 * k);
      cmp("gap", k > 10 ? 10 : k, gap);
    end
    // stop clears the divider and drive; release clears it again, prescaler phase survives
    ticks(2);
    repeat (2) @(posedge clk);
    cmp("drive", 1, fout);
    apb(1'b1, `SCTG_SYS_CTRL_OFF, 32'h81);
    apb(1'b0, `SCTG_STATUS_OFF, 0);
    cmp("standby", 3'h1, rd[4:2]);
    cmp("clear", 0, taps);
    cmp("drive", 0, fout);
    srel <= 1'b1;
    @(posedge clk);
    srel <= 1'b0;
    nen = 0;
    ticks(42);
    repeat (2) @(posedge clk);
    cmp("warm", 21'h00000b, taps);
    cmp("warmclk", 0, nen);
    apb(1'b0, `SCTG_STATUS_OFF, 0);
    cmp("standby", 3'h2, rd[4:2]);
    // dual mode: the source switch waits for the end of a machine cycle
    do_reset(1'b1);
    spin <= 1'b1;
    cmp("port", 0, spp);
    apb(1'b1, `SCTG_TIME_BASE_CTRL_OFF, 32'h90);
    apb(1'b0, `SCTG_TIME_BASE_CTRL_OFF, 0);
    cmp("tbase", 32'h90, rd);
    apb(1'b1, `SCTG_SYS_CTRL_OFF, 32'hc0);
    apb(1'b1, `SCTG_SYS_CTRL_OFF, 32'he0);
    apb(1'b0, `SCTG_SYS_CTRL_OFF, 0);
    cmp("src", 0, rd[5]);
    ticks(4);
    apb(1'b0, `SCTG_SYS_CTRL_OFF, 0);
    cmp("src", 1, rd[5]);
    t0 = taps;
    // fast edges keep coming so a frozen low divider is really tested
    ticks(700);
    cmp("period", 16'h0262, per);
    cmp("freeze", t0[5:0], taps[5:0]);
    apb(1'b1, `SCTG_SYS_CTRL_OFF, 0);
    i = 0;
    while (rreq !== 1'b0 && i < 20) begin
      @(posedge clk);
      i++;
    end
    cmp("rstreq", 0, rreq);
    print_verdict();
  end
endmodule
